// >>> rtl/acs_serial_top.sv
/*
  Dual-channel asynchronous serial controller with an APB register slave.
  Each channel has a data port and a pointer-driven control port, its own
  receive and transmit bit clocks and modem status inputs.
  Assumes a 200 MHz mclk, synchronous active-high reset and bit clocks no
  faster than one fifth of mclk; all pins are asynchronous to mclk.
*/
// Functional notes
// - Received character readable within 13 mclk of the last-bit clock edge.
// - Receiver and transmitter take separate bit clocks, one shared multiplier.
// - Transmit-empty flag and interrupt only once the buffer is truly empty.
// - Receive-available flag and interrupt only after the whole character lands.
// - Overrun latches the flag; the newest character overwrites the unread one.
// - Carrier or clear-to-send changes interrupt even with automatic enables.
// - Interrupt request stays asserted while its condition and enable persist.
// - Clearing transmit enable mid-character still completes that character.
// - Clearing receive enable mid-character discards it without an interrupt.
// - Any status-input transition freezes status register zero until a reset-status command or reset.
// - Reset-status command releases the freeze and clears no status bit.
// - After reset-transmit-pending, no empty interrupt until the next write.
// - Error-reset command clears latched receive error flags.
`timescale 1ns/10ps
module acs_serial_top
  import acs_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int CHANNELS = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CHANNELS-1:0] rxd,
  input wire logic [CHANNELS-1:0] rxBitClock,
  input wire logic [CHANNELS-1:0] txBitClock,
  input wire logic [CHANNELS-1:0] carrierDetect,
  input wire logic [CHANNELS-1:0] clearToSend,
  input wire logic [CHANNELS-1:0] syncIn,
  output logic [CHANNELS-1:0] txd,
  output logic intRequest
);

  // ************************************************************
  // Shared helpers
  // ************************************************************

  // Bit-clock edges per serial bit for a multiplier code
  function automatic logic [6:0] bitTicks(input logic [1:0] code);
    unique case (code)
      MULT_X1: bitTicks = TICKS_X1;
      MULT_X16: bitTicks = TICKS_X16;
      MULT_X32: bitTicks = TICKS_X32;
      MULT_X64: bitTicks = TICKS_X64;
    endcase
  endfunction : bitTicks

  localparam int SYNC_W = 6 * CHANNELS;

  logic [SYNC_W-1:0] syncLevel, syncRise;

  // All pins and bit clocks pass the agreement synchroniser
  acs_pin_sync #(.WIDTH(SYNC_W)) pinSync (
    .mclk(mclk),
    .rst(rst),
    .pinIn({syncIn, clearToSend, carrierDetect, txBitClock, rxBitClock, rxd}),
    .level(syncLevel),
    .rise(syncRise)
  );

  // ************************************************************
  // APB slave
  // ************************************************************
  logic apbDone, addrMapped, busCh, busCtrl;
  logic [7:0] readByte;

  logic [2:0] regPtr [CHANNELS];
  logic [7:0] rxBuf [CHANNELS], sr0Read [CHANNELS], sr1Value [CHANNELS];
  logic chanInt [CHANNELS];

  assign apbDone = psel & penable & pready;
  assign addrMapped = (paddr[ADDR_WIDTH-1:4] == '0) && (paddr[1:0] == 2'h0);
  assign busCh = paddr[3];
  assign busCtrl = paddr[2];

  // Read mux; control reads follow the channel pointer
  assign readByte = !busCtrl ? rxBuf[busCh] :
                    (regPtr[busCh] == PTR_REG1) ? sr1Value[busCh] : sr0Read[busCh];

  // One wait state; data captured in the first access cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addrMapped; // Stands with pready only
      if (psel && penable && !pready) begin
        prdata <= (pwrite || !addrMapped) ? 32'h0000_0000 : {24'h00_0000, readByte};
      end
    end
  end

  // Combined request of both channels
  always_ff @(posedge mclk) begin
    if (rst) begin
      intRequest <= 1'b0;
    end else begin
      intRequest <= chanInt[0] | chanInt[1];
    end
  end

  // ************************************************************
  // Channels
  // ************************************************************
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : gChan
    logic dataWr, dataRd, ctrlWr, ctrlRd, chRst, cmdResetExt, cmdErrReset, cmdResetTx;
    logic [2:0] cmdCode, rxBit, txBit;
    logic [7:0] wr1, wr3, wr4, wr5, rxShift, txShift, txBuf, sr0Live, sr0Frozen;
    logic [6:0] ticks, rxCnt, txCnt;
    logic rxLvl, rxTick, txTick, dcdLvl, ctsLvl, syncLvl, extLatched;
    acs_rx_state_t rxState;
    acs_tx_state_t txState;
    logic rxDone, rxAvail, overrun, framingErr, rxBreak;
    logic txFull, txIntPend, txGo, txLine, txPin, txIdle;
    logic [4:0] extLive, extLast;

    // Bus events for this channel, effective only at the completing edge
    assign dataWr = apbDone & pwrite & addrMapped & (busCh == 1'(ch)) & ~busCtrl;
    assign dataRd = apbDone & ~pwrite & addrMapped & (busCh == 1'(ch)) & ~busCtrl;
    assign ctrlWr = apbDone & pwrite & addrMapped & (busCh == 1'(ch)) & busCtrl;
    assign ctrlRd = apbDone & ~pwrite & addrMapped & (busCh == 1'(ch)) & busCtrl;
    assign cmdCode = (ctrlWr && regPtr[ch] == PTR_REG0) ?
                     pwdata[CMD_LSB+2:CMD_LSB] : CMD_NULL;
    assign chRst = rst | (cmdCode == CMD_CHAN_RESET);
    assign cmdResetExt = (cmdCode == CMD_RESET_EXT);
    assign cmdErrReset = (cmdCode == CMD_ERROR_RESET);
    assign cmdResetTx = (cmdCode == CMD_RESET_TXINT);

    // Separate bit clocks per direction, one multiplier setting
    assign ticks = bitTicks(wr4[WR4_MULT_LSB+1:WR4_MULT_LSB]);
    assign rxLvl = syncLevel[ch];
    assign rxTick = syncRise[CHANNELS+ch];
    assign txTick = syncRise[2*CHANNELS+ch]; // Clock at 1/5 mclk still edges cleanly
    assign dcdLvl = syncLevel[3*CHANNELS+ch];
    assign ctsLvl = syncLevel[4*CHANNELS+ch];
    assign syncLvl = syncLevel[5*CHANNELS+ch];

    // Pointer: a command-register write aims it, any other control-port access resets it
    always_ff @(posedge mclk) begin
      if (chRst || ctrlRd || (ctrlWr && regPtr[ch] != PTR_REG0)) begin
        regPtr[ch] <= PTR_REG0;
      end else if (ctrlWr) begin
        regPtr[ch] <= pwdata[2:0];
      end
    end

    // Write registers; unimplemented pointer values are ignored
    always_ff @(posedge mclk) begin
      if (chRst) begin
        wr1 <= WREG_RESET;
        wr3 <= WREG_RESET;
        wr4 <= WREG_RESET;
        wr5 <= WREG_RESET;
      end else if (ctrlWr) begin
        if (regPtr[ch] == PTR_REG1) wr1 <= pwdata[7:0];
        if (regPtr[ch] == PTR_REG3) wr3 <= pwdata[7:0];
        if (regPtr[ch] == PTR_REG4) wr4 <= pwdata[7:0];
        if (regPtr[ch] == PTR_REG5) wr5 <= pwdata[7:0];
      end
    end

    // Receiver: 8 data bits, one stop bit, sampled mid-bit when multiplied
    always_ff @(posedge mclk) begin
      if (chRst || !wr3[WR3_RX_EN]) begin
        rxState <= RX_IDLE; // Partial character dropped on disable
        rxCnt <= 7'h00;
        rxBit <= 3'h0;
        rxShift <= 8'h00;
      end else if (rxTick) begin
        unique case (rxState)
          RX_IDLE: begin
            if (!rxLvl) begin
              // x1 takes data from the next edge; xN rechecks the start mid-bit
              rxState <= (ticks == TICKS_X1) ? RX_DATA : RX_START;
              rxCnt <= (ticks == TICKS_X1) ? 7'h00 : (ticks >> 1) - 7'h01;
            end
          end
          RX_START: begin
            if (rxCnt != 7'h00) begin
              rxCnt <= rxCnt - 7'h01;
            end else begin
              // A start bit that has gone high again is a glitch
              rxState <= rxLvl ? RX_IDLE : RX_DATA;
              rxCnt <= ticks - 7'h01;
            end
          end
          RX_DATA: begin
            if (rxCnt != 7'h00) begin
              rxCnt <= rxCnt - 7'h01;
            end else begin
              rxShift <= {rxLvl, rxShift[7:1]};
              rxCnt <= ticks - 7'h01;
              rxBit <= rxBit + 3'h1;
              if (rxBit == LAST_DATA_BIT) rxState <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rxCnt != 7'h00) begin
              rxCnt <= rxCnt - 7'h01;
            end else begin
              rxState <= RX_IDLE;
            end
          end
        endcase
      end
    end

    // Completion is on the edge that samples the stop bit
    assign rxDone = rxTick & (rxState == RX_STOP) & (rxCnt == 7'h00) & wr3[WR3_RX_EN];

    // Receive buffer and sticky errors; hardware set wins over clear
    always_ff @(posedge mclk) begin
      if (chRst) begin
        rxBuf[ch] <= 8'h00;
        rxAvail <= 1'b0;
        overrun <= 1'b0;
        framingErr <= 1'b0;
        rxBreak <= 1'b0;
      end else begin
        if (rxDone) rxBuf[ch] <= rxShift; // Newest overwrites unread
        rxAvail <= rxDone | (rxAvail & ~dataRd); // Whole character in buffer
        overrun <= (rxDone & rxAvail & ~dataRd) | (overrun & ~cmdErrReset);
        framingErr <= (rxDone & ~rxLvl) | (framingErr & ~cmdErrReset);
        rxBreak <= (rxDone & ~rxLvl & (rxShift == 8'h00)) | (rxBreak & ~rxLvl);
      end
    end

    // Start only between characters; auto enable waits for clear-to-send
    assign txGo = txTick & (txState == TX_IDLE) & txFull & wr5[WR5_TX_EN] &
                  (~wr3[WR3_AUTO_EN] | ctsLvl);

    // Transmit buffer and its pending interrupt
    always_ff @(posedge mclk) begin
      if (chRst) begin
        txBuf <= 8'h00;
        txFull <= 1'b0;
        txIntPend <= 1'b0;
      end else begin
        if (dataWr) txBuf <= pwdata[7:0];
        txFull <= dataWr | (txFull & ~txGo);
        // Pending only once the buffer has emptied into the shifter
        txIntPend <= txGo | (txIntPend & ~(cmdResetTx | dataWr));
      end
    end

    // Transmit shifter; enable is only looked at between characters
    always_ff @(posedge mclk) begin
      if (chRst) begin
        txState <= TX_IDLE;
        txCnt <= 7'h00;
        txBit <= 3'h0;
        txShift <= 8'h00;
        txLine <= 1'b1;
      end else if (txTick) begin
        unique case (txState)
          TX_IDLE: begin
            if (txGo) begin
              txShift <= txBuf;
              txLine <= 1'b0;
              txCnt <= ticks - 7'h01;
              txState <= TX_START;
            end
          end
          TX_START: begin
            if (txCnt != 7'h00) begin
              txCnt <= txCnt - 7'h01;
            end else begin
              txLine <= txShift[0];
              txBit <= 3'h0;
              txCnt <= ticks - 7'h01;
              txState <= TX_DATA;
            end
          end
          TX_DATA: begin // A disable here does not cut the character short
            if (txCnt != 7'h00) begin
              txCnt <= txCnt - 7'h01;
            end else if (txBit == LAST_DATA_BIT) begin
              txLine <= 1'b1;
              txCnt <= ticks - 7'h01;
              txState <= TX_STOP;
            end else begin
              txLine <= txShift[1];
              txShift <= {1'b0, txShift[7:1]};
              txBit <= txBit + 3'h1;
              txCnt <= ticks - 7'h01;
            end
          end
          TX_STOP: begin
            if (txCnt != 7'h00) begin
              txCnt <= txCnt - 7'h01;
            end else begin
              txState <= TX_IDLE;
            end
          end
        endcase
      end
    end

    // Break forces spacing at once, even mid-character
    always_ff @(posedge mclk) begin
      if (chRst) begin
        txPin <= 1'b1;
      end else begin
        txPin <= wr5[WR5_BREAK] ? 1'b0 : txLine;
      end
    end
    assign txd[ch] = txPin;

    assign txIdle = (txState == TX_IDLE) & ~txFull;

    // Status inputs; carrier and clear-to-send are watched even in auto mode
    assign extLive = {rxBreak, txIdle, ctsLvl, syncLvl, dcdLvl};
    assign sr0Live = {extLive, ~txFull, chanInt[ch], rxAvail};

    // Freeze on a transition; the reset command only releases it
    always_ff @(posedge mclk) begin
      if (chRst) begin
        extLast <= 5'h00;
        extLatched <= 1'b0;
        sr0Frozen <= 8'h00;
      end else begin
        extLast <= extLive;
        if (extLive != extLast && (!extLatched || cmdResetExt)) begin
          extLatched <= 1'b1;
          sr0Frozen <= sr0Live;
        end else if (cmdResetExt) begin
          extLatched <= 1'b0;
        end
      end
    end

    assign sr0Read[ch] = extLatched ? sr0Frozen : sr0Live;
    assign sr1Value[ch] = {1'b0, framingErr, overrun, 4'h0, (txState == TX_IDLE)};

    // Level request that persists while any enabled cause stands
    assign chanInt[ch] = (wr1[WR1_EXT_IE] & extLatched) |
                         (wr1[WR1_TX_IE] & txIntPend) |
                         (wr1[WR1_RX_IE] & (rxAvail | overrun | framingErr));
  end

endmodule : acs_serial_top

// >>> rtl/acs_pkg.sv
/*
  Shared constants for the dual-channel asynchronous serial block: APB
  offsets, pointer values, command codes, field positions, reset values,
  receiver and transmitter state encodings.
  Assumes nothing of its surroundings; imported by every design file.
*/
package acs_pkg;

  // ************************************************************
  // APB byte offsets, one 32-bit word per port
  // ************************************************************
  localparam logic [7:0] OFF_DATA_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_A = 8'h04;
  localparam logic [7:0] OFF_DATA_B = 8'h08;
  localparam logic [7:0] OFF_CTRL_B = 8'h0C;

  // ************************************************************
  // Register pointer values held by command_register_0
  // ************************************************************
  localparam logic [2:0] PTR_REG0 = 3'h0;
  localparam logic [2:0] PTR_REG1 = 3'h1;
  localparam logic [2:0] PTR_REG3 = 3'h3;
  localparam logic [2:0] PTR_REG4 = 3'h4;
  localparam logic [2:0] PTR_REG5 = 3'h5;

  // Command field of command_register_0, bits 5..3
  localparam int CMD_LSB = 3;
  localparam logic [2:0] CMD_NULL = 3'h0;
  localparam logic [2:0] CMD_RESET_EXT = 3'h2;
  localparam logic [2:0] CMD_CHAN_RESET = 3'h3;
  localparam logic [2:0] CMD_RESET_TXINT = 3'h5;
  localparam logic [2:0] CMD_ERROR_RESET = 3'h6;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int WR1_EXT_IE = 0;
  localparam int WR1_TX_IE = 1;
  localparam int WR1_RX_IE = 3;
  localparam int WR3_RX_EN = 0;
  localparam int WR3_AUTO_EN = 5;
  localparam int WR4_MULT_LSB = 6;
  localparam int WR5_TX_EN = 3;
  localparam int WR5_BREAK = 4;
  localparam int SR0_TX_EMPTY = 2;
  localparam int SR0_RX_AVAIL = 0;
  localparam int SR1_ALL_SENT = 0;
  localparam int SR1_OVERRUN = 5;
  localparam int SR1_FRAMING = 6;

  // Clock multiplier codes and their bit-clock edges per bit
  localparam logic [1:0] MULT_X1 = 2'h0;
  localparam logic [1:0] MULT_X16 = 2'h1;
  localparam logic [1:0] MULT_X32 = 2'h2;
  localparam logic [1:0] MULT_X64 = 2'h3;
  localparam logic [6:0] TICKS_X1 = 7'h01;
  localparam logic [6:0] TICKS_X16 = 7'h10;
  localparam logic [6:0] TICKS_X32 = 7'h20;
  localparam logic [6:0] TICKS_X64 = 7'h40;

  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam int RX_READY_MAX_CYCLES = 13;
  localparam int MIN_MCLK_PER_BIT = 5;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } acs_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } acs_tx_state_t;

endpackage : acs_pkg

// >>> rtl/acs_pin_sync.sv
/*
  Three-stage synchroniser with agreement filter for pins and bit clocks.
  Assumes all inputs are asynchronous to mclk and change no faster than
  one level per two mclk periods.
*/
`timescale 1ns/10ps
module acs_pin_sync
  import acs_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  // ************************************************************
  // Capture chain; stage1 feeds stage2 only
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change is accepted only once stages two and three agree
  assign agree = ~(stage2 ^ stage3);

  // Filtered level and a one-cycle pulse on each accepted rising change
  always_ff @(posedge mclk) begin
    if (rst) begin
      level <= '0;
      rise <= '0;
    end else begin
      level <= (level & ~agree) | (stage3 & agree);
      rise <= agree & stage3 & ~level;
    end
  end

endmodule : acs_pin_sync

// >>> testbench/acs_serial_properties.sv
/* Checker on the top ports: APB answer timing, reset state, line pacing.
   Assumes a bind to acs_serial_top and a single mclk domain. */
`timescale 1ns/10ps
module acs_serial_properties
  import acs_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int CHANNELS = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CHANNELS-1:0] txd,
  input wire logic intRequest
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_delay_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (pready && paddr[7:4] != 4'h0 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  // Reset itself is the cause here, so this one must not be disabled by it
  reset_idle_a: assert property (disable iff (1'b0) rst |=> (&txd) && !intRequest && !pready)
    else $error("outputs not idle after reset");
  // A bit lasts at least five mclk even at the fastest bit clock
  tx_bit_hold_a: assert property ($changed(txd[1]) |=> $stable(txd[1]) [*4])
    else $error("transmit bit too short");
endmodule : acs_serial_properties

bind acs_serial_top acs_serial_properties #(.ADDR_WIDTH(ADDR_WIDTH), .CHANNELS(CHANNELS))
  u_props (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd), .intRequest(intRequest));

// >>> testbench/acs_link_model.sv
/* Remote terminal on both serial channels, x1 clocking, 80 ns bits.
   Assumes the bench calls its tasks one at a time per channel. */
`timescale 1ns/10ps
module acs_link_model (
  output logic [1:0] rxd,
  output logic [1:0] rxBitClock,
  output logic [1:0] txBitClock,
  input wire logic [1:0] txd
);
  // Line idles at mark; bit clocks stand still low between frames
  initial begin
    rxd = 2'h3;
    rxBitClock = 2'h0;
    txBitClock = 2'h0;
  end

  // Start, eight bits LSB first, stop; own receive clock per channel
  task automatic sendByte(input logic ch, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    #1.3;
    for (int i = 0; i < 10; i++) begin
      rxd[ch] = f[i];
      #40 rxBitClock[ch] = 1'b1;
      #40 rxBitClock[ch] = 1'b0;
    end
  endtask : sendByte

  // Separate transmit clock sample just before each rise, when settled
  task automatic catchByte(input logic ch, output logic [9:0] f);
    #2.7;
    for (int k = 0; k < 11; k++) begin
      if (k > 0) f[k-1] = txd[ch];
      txBitClock[ch] = 1'b1;
      #40 txBitClock[ch] = 1'b0;
      #40;
    end
  endtask : catchByte
endmodule : acs_link_model

// >>> testbench/async_serial_channel_tb.sv
/* Self-checking bench: APB master tasks and scripted serial traffic.
   Assumes acs_link_model drives the link and the checker is bound. */
`timescale 1ns/10ps
module async_serial_channel_tb;
  import acs_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic lastErr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, intRequest;
  logic [1:0] rxd, rxBitClock, txBitClock, txd;
  logic [1:0] carrierDetect = 2'h0;
  logic [1:0] clearToSend = 2'h0;
  logic [1:0] syncIn = 2'h0; // Strapped so it never interrupts
  logic [7:0] rv, junk;
  logic [9:0] fr;
  int errors = 0;
  int samplesChecked = 0;

  // 200 MHz system clock
  always #2.5 mclk = ~mclk;

  acs_serial_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .rxBitClock(rxBitClock), .txBitClock(txBitClock),
    .carrierDetect(carrierDetect), .clearToSend(clearToSend), .syncIn(syncIn),
    .txd(txd), .intRequest(intRequest));
  acs_link_model link (.rxd(rxd), .rxBitClock(rxBitClock), .txBitClock(txBitClock),
    .txd(txd));

  task automatic complete_run();
    $display("Compares %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("BAD t=%0t no pready", $time);
      complete_run();
    end
    r = prdata[7:0];
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Pointer first, then the register itself
  task automatic setReg(input logic ch, input logic [2:0] p, input logic [7:0] v);
    xfer(1'b1, {4'h0, ch, 3'h4}, {5'h0, p}, junk);
    xfer(1'b1, {4'h0, ch, 3'h4}, v, junk);
  endtask : setReg

  task automatic cmd(input logic ch, input logic [2:0] c);
    xfer(1'b1, {4'h0, ch, 3'h4}, {2'h0, c, 3'h0}, junk);
  endtask : cmd

  task automatic rd(input logic ch, input logic [2:0] p);
    if (p != PTR_REG0) xfer(1'b1, {4'h0, ch, 3'h4}, {5'h0, p}, junk);
    xfer(1'b0, {4'h0, ch, 3'h4}, 8'h00, rv);
  endtask : rd

  // Hang guard
  initial begin
    #300000;
    errors++;
    $display("BAD t=%0t timeout", $time);
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int c = 0; c < 2; c++) begin
      cmd(c[0], CMD_RESET_EXT);
      setReg(c[0], PTR_REG4, {MULT_X1, 6'h0});
      setReg(c[0], PTR_REG3, 8'h01);
      setReg(c[0], PTR_REG5, 8'h08);
    end
    chk({7'h0, intRequest}, 8'h00);
    chk({6'h0, txd}, 8'h03);
    xfer(1'b0, 8'h10, 8'h00, rv);
    chk({7'h0, lastErr}, 8'h01);
    chk(rv, 8'h00);
    $display("map test done");
    // Receive on A, read well inside the 13-cycle window
    link.sendByte(1'b0, 8'hA5);
    rd(1'b0, PTR_REG0);
    chk(rv & 8'h01, 8'h01);
    xfer(1'b0, 8'h00, 8'h00, rv);
    chk(rv, 8'hA5);
    $display("receive test done");
    // Two unread characters: newest wins, then error reset clears the flag
    link.sendByte(1'b0, 8'h11);
    link.sendByte(1'b0, 8'h22);
    rd(1'b0, PTR_REG1);
    chk(rv & 8'h20, 8'h20);
    xfer(1'b0, 8'h00, 8'h00, rv);
    chk(rv, 8'h22);
    cmd(1'b0, CMD_ERROR_RESET);
    rd(1'b0, PTR_REG1);
    chk(rv & 8'h20, 8'h00);
    $display("overrun test done");
    // Transmit on B; clock still, so the byte must wait in the buffer
    setReg(1'b1, PTR_REG1, 8'h02);
    xfer(1'b1, 8'h08, 8'h3C, junk);
    rd(1'b1, PTR_REG0);
    chk(rv & 8'h04, 8'h00);
    fork
      link.catchByte(1'b1, fr);
      begin
        #300;
        setReg(1'b1, PTR_REG5, 8'h00);
      end
    join
    chk(fr[8:1], 8'h3C);
    chk({6'h0, fr[9], fr[0]}, 8'h02);
    cmd(1'b1, CMD_RESET_EXT);
    rd(1'b1, PTR_REG0);
    chk(rv & 8'h04, 8'h04);
    chk({7'h0, intRequest}, 8'h01);
    cmd(1'b1, CMD_RESET_TXINT);
    repeat (4) @(posedge mclk);
    chk({7'h0, intRequest}, 8'h00);
    $display("transmit test done");
    // Status pins on A with automatic enables set
    setReg(1'b0, PTR_REG3, 8'h21);
    setReg(1'b0, PTR_REG1, 8'h01);
    @(posedge mclk) carrierDetect <= 2'h1;
    repeat (20) @(posedge mclk);
    chk({7'h0, intRequest}, 8'h01);
    @(posedge mclk) clearToSend <= 2'h1;
    repeat (20) @(posedge mclk);
    rd(1'b0, PTR_REG0);
    chk(rv & 8'h20, 8'h00);
    chk({7'h0, intRequest}, 8'h01);
    cmd(1'b0, CMD_RESET_EXT);
    repeat (4) @(posedge mclk);
    rd(1'b0, PTR_REG0);
    chk(rv & 8'h28, 8'h28);
    chk({7'h0, intRequest}, 8'h00);
    $display("status test done");
    // Channel reset drops an unread character on channel A
    link.sendByte(1'b0, 8'h5A);
    rd(1'b0, PTR_REG0);
    chk(rv & 8'h01, 8'h01);
    cmd(1'b0, CMD_CHAN_RESET);
    xfer(1'b0, 8'h00, 8'h00, rv);
    chk(rv, 8'h00);
    $display("channel reset test done");
    complete_run();
  end
endmodule : async_serial_channel_tb
